// ==== rtl/jtag_tap_pkg.sv ====
// Purpose: Shared types and constants of the test access port
// Assumes: Link logic on TCK_I, array side on CLK_I
// Notes:   Opcodes and identity values are defaults only
`default_nettype none
package jtag_tap_pkg;

  typedef enum logic [3:0] {
    TLR    = 4'h0,
    RTI    = 4'h1,
    SEL_DR = 4'h3,
    CAP_DR = 4'h2,
    SH_DR  = 4'h6,
    EX1_DR = 4'h7,
    PAU_DR = 4'h5,
    EX2_DR = 4'h4,
    UPD_DR = 4'hC,
    SEL_IR = 4'hD,
    CAP_IR = 4'hF,
    SH_IR  = 4'hE,
    EX1_IR = 4'hA,
    PAU_IR = 4'hB,
    EX2_IR = 4'h9,
    UPD_IR = 4'h8
  } tap_state_t;

  localparam int IR_W        = 4;
  localparam int ID_W        = 32;
  localparam int ROW_W       = 8;
  localparam int DATA_W      = 16;
  localparam int ISP_W       = ROW_W + DATA_W;
  localparam int BSR_LEN_DEF = 16;

  localparam logic [IR_W-1:0] OP_EXTEST_DEF   = 4'h0;
  localparam logic [IR_W-1:0] OP_SAMPLE_DEF   = 4'h1;
  localparam logic [IR_W-1:0] OP_IDCODE_DEF   = 4'h2;
  localparam logic [IR_W-1:0] OP_USERCODE_DEF = 4'h3;
  localparam logic [IR_W-1:0] OP_HIGHZ_DEF    = 4'h4;
  localparam logic [IR_W-1:0] OP_PROG_DEF     = 4'h8;
  localparam logic [IR_W-1:0] OP_READ_DEF     = 4'h9;
  localparam logic [IR_W-1:0] OP_BYPASS_DEF   = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE      = 4'h1;

  // Arbitrary identity values
  localparam logic [ID_W-1:0] IDCODE_DEF   = 32'h0000_0001;
  localparam logic [ID_W-1:0] USERCODE_DEF = 32'h0000_0000;
  localparam logic            BYPASS_CAP   = 1'h0;

  typedef struct packed {
    logic [ROW_W-1:0]  row;
    logic [DATA_W-1:0] data;
  } isp_word_t;

  typedef struct packed {
    logic      write;
    isp_word_t word;
  } isp_req_t;

  typedef struct packed {
    logic extest;
    logic highz;
    logic isp;
  } test_mode_t;

  function automatic logic is_shift_state(input tap_state_t s);
    return (s == SH_DR) || (s == SH_IR);
  endfunction : is_shift_state

endpackage : jtag_tap_pkg
`default_nettype wire

// ==== rtl/level_sync.sv ====
// Purpose: Three-stage level synchroniser with agreement filter
// Assumes: Input is a level from another clock or a pin
// Notes:   Output follows once stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module level_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  // Level in and out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  logic [W-1:0] q_ff;
  wire  [W-1:0] nxt_q = (~(s2_ff ^ s3_ff) & s3_ff) | ((s2_ff ^ s3_ff) & q_ff);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff  <= '0;
    end else begin
      s1_ff <= d_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q_ff  <= nxt_q;
    end
  end

  assign q_o = q_ff;

endmodule : level_sync
`default_nettype wire

// ==== rtl/tap_state_machine.sv ====
// Purpose: Sixteen-state test access controller
// Assumes: TMS is driven on the TCK domain by the host
// Notes:   Reset state is forced asynchronously
`timescale 1ns/10ps
`default_nettype none
module tap_state_machine
  import jtag_tap_pkg::*;
(
  // Link clock and reset
  input  wire logic  tck_i,
  input  wire logic  rst_b_i,
  // Mode select
  input  wire logic  tms_i,
  // Controller state
  output var tap_state_t state_o
);

  tap_state_t state_ff;
  tap_state_t nxt_state;

  function automatic tap_state_t step(input tap_state_t s, input logic tms);
    tap_state_t n;
    n = s;
    unique case (s)
      TLR:    n = tms ? TLR    : RTI;
      RTI:    n = tms ? SEL_DR : RTI;
      SEL_DR: n = tms ? SEL_IR : CAP_DR;
      CAP_DR: n = tms ? EX1_DR : SH_DR;
      SH_DR:  n = tms ? EX1_DR : SH_DR;
      EX1_DR: n = tms ? UPD_DR : PAU_DR;
      PAU_DR: n = tms ? EX2_DR : PAU_DR;
      EX2_DR: n = tms ? UPD_DR : SH_DR;
      UPD_DR: n = tms ? SEL_DR : RTI;
      SEL_IR: n = tms ? TLR    : CAP_IR;
      CAP_IR: n = tms ? EX1_IR : SH_IR;
      SH_IR:  n = tms ? EX1_IR : SH_IR;
      EX1_IR: n = tms ? UPD_IR : PAU_IR;
      PAU_IR: n = tms ? EX2_IR : PAU_IR;
      EX2_IR: n = tms ? UPD_IR : SH_IR;
      UPD_IR: n = tms ? SEL_DR : RTI;
    endcase
    return n;
  endfunction : step

  assign nxt_state = step(state_ff, tms_i);

  always_ff @(posedge tck_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= TLR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign state_o = state_ff;

  sequence tms_high5_s;
    tms_i [*5];
  endsequence

  five_ones_a: assert property (@(posedge tck_i) disable iff (!rst_b_i)
    tms_high5_s |=> (state_ff == TLR)) else $error("Five TMS-high edges missed reset");
  tlr_hold_a: assert property (@(posedge tck_i) disable iff (!rst_b_i)
    (state_ff == TLR) && tms_i |=> (state_ff == TLR)) else $error("Reset state left with TMS high");
  dr_path_a: assert property (@(posedge tck_i) disable iff (!rst_b_i)
    (state_ff == SEL_DR) && !tms_i ##1 !tms_i |=> (state_ff == SH_DR)) else $error("Data scan path broken");

endmodule : tap_state_machine
`default_nettype wire

// ==== rtl/jtag_tap_isp_port.sv ====
// Purpose: Test access port with boundary scan and array programming
// Assumes: TCK_I unrelated to CLK_I; array answers on CLK_I
// Notes:   Readback data appears at the next data capture
`timescale 1ns/10ps
`default_nettype none
module jtag_tap_isp_port
  import jtag_tap_pkg::*;
#(
  parameter int              BSR_LEN     = BSR_LEN_DEF,
  parameter logic [IR_W-1:0] OP_EXTEST   = OP_EXTEST_DEF,
  parameter logic [IR_W-1:0] OP_SAMPLE   = OP_SAMPLE_DEF,
  parameter logic [IR_W-1:0] OP_IDCODE   = OP_IDCODE_DEF,
  parameter logic [IR_W-1:0] OP_USERCODE = OP_USERCODE_DEF,
  parameter logic [IR_W-1:0] OP_HIGHZ    = OP_HIGHZ_DEF,
  parameter logic [IR_W-1:0] OP_PROG     = OP_PROG_DEF,
  parameter logic [IR_W-1:0] OP_READ     = OP_READ_DEF,
  parameter logic [IR_W-1:0] OP_BYPASS   = OP_BYPASS_DEF,
  parameter logic [ID_W-1:0] IDCODE_VAL  = IDCODE_DEF,
  parameter logic [ID_W-1:0] USERCODE_VAL = USERCODE_DEF
) (
  // System clock and reset
  input  wire logic               CLK_I,
  input  wire logic               RST_B_I,
  // Test port
  input  wire logic               TCK_I,
  input  wire logic               TMS_I,
  input  wire logic               TDI_I,
  input  wire logic               TRST_B_I,
  output logic                    TDO_O,
  output logic                    TDO_OE_O,
  // Boundary cells
  input  wire logic [BSR_LEN-1:0] PIN_IN_I,
  output logic      [BSR_LEN-1:0] PIN_OUT_O,
  output logic                    PIN_TEST_O,
  output logic                    PIN_HIZ_O,
  // Test mode seen by system logic
  output var test_mode_t          MODE_O,
  // Nonvolatile array
  input  wire logic               SEC_I,
  input  wire logic               ARRAY_ACK_I,
  input  wire logic [DATA_W-1:0]  ARRAY_RDATA_I,
  output logic                    PROG_STB_O,
  output var isp_req_t            PROG_REQ_O
);

  // Reset release
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic trst_meta_ff;
  logic trst_sync_ff;
  wire  tck_src_b = rst_sync_ff & TRST_B_I;
  wire  tck_rst_b = trst_sync_ff;

  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_meta_ff <= 1'h0;
      rst_sync_ff <= 1'h0;
    end else begin
      rst_meta_ff <= 1'h1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  always_ff @(posedge TCK_I or negedge tck_src_b) begin
    if (!tck_src_b) begin
      trst_meta_ff <= 1'h0;
      trst_sync_ff <= 1'h0;
    end else begin
      trst_meta_ff <= 1'h1;
      trst_sync_ff <= trst_meta_ff;
    end
  end

  // Controller
  tap_state_t state;

  tap_state_machine u_fsm (
    .tck_i   (TCK_I),
    .rst_b_i (tck_rst_b),
    .tms_i   (TMS_I),
    .state_o (state)
  );

  // Link-side registers
  logic [IR_W-1:0]    ir_shift_ff;
  logic [IR_W-1:0]    ir_cur_ff;
  logic               bypass_ff;
  logic [ID_W-1:0]    id_shift_ff;
  logic [BSR_LEN-1:0] bsr_shift_ff;
  logic [BSR_LEN-1:0] bsr_upd_ff;
  isp_word_t          isp_shift_ff;
  isp_req_t           req_ff;
  logic               req_tgl_ff;
  test_mode_t         mode_ff;
  logic               tdo_ff;
  logic               tdo_oe_ff;

  // Array-side registers
  logic               req_seen_ff;
  logic               stb_ff;
  isp_req_t           prog_req_ff;
  logic [DATA_W-1:0]  rd_hold_ff;
  logic               ack_tgl_ff;
  test_mode_t         mode_last_ff;
  test_mode_t         mode_out_ff;

  // Crossings
  logic [BSR_LEN-1:0] pins_s;
  logic               sec_s;
  logic               ack_s;
  logic               req_s;
  test_mode_t         mode_s;

  level_sync #(.W(BSR_LEN)) u_pin_sync (
    .clk_i   (TCK_I),
    .rst_b_i (tck_rst_b),
    .d_i     (PIN_IN_I),
    .q_o     (pins_s)
  );

  level_sync #(.W(2)) u_flag_sync (
    .clk_i   (TCK_I),
    .rst_b_i (rst_sync_ff),
    .d_i     ({SEC_I, ack_tgl_ff}),
    .q_o     ({sec_s, ack_s})
  );

  level_sync #(.W(1)) u_req_sync (
    .clk_i   (CLK_I),
    .rst_b_i (rst_sync_ff),
    .d_i     (req_tgl_ff),
    .q_o     (req_s)
  );

  level_sync #(.W(3)) u_mode_sync (
    .clk_i   (CLK_I),
    .rst_b_i (rst_sync_ff),
    .d_i     (mode_ff),
    .q_o     (mode_s)
  );

  function automatic test_mode_t mode_of(input logic [IR_W-1:0] op);
    test_mode_t m;
    m.extest = (op == OP_EXTEST);
    m.highz  = (op == OP_HIGHZ);
    m.isp    = (op == OP_PROG) || (op == OP_READ);
    return m;
  endfunction : mode_of

  // State decode
  wire in_tlr    = (state == TLR);
  wire in_rti    = (state == RTI);
  wire in_cap_dr = (state == CAP_DR);
  wire in_sh_dr  = (state == SH_DR);
  wire in_upd_dr = (state == UPD_DR);
  wire in_cap_ir = (state == CAP_IR);
  wire in_sh_ir  = (state == SH_IR);
  wire in_upd_ir = (state == UPD_IR);

  // Instruction decode, unknown codes and high-z select bypass
  wire op_id   = (ir_cur_ff == OP_IDCODE);
  wire op_user = (ir_cur_ff == OP_USERCODE);
  wire op_idu  = op_id | op_user;
  wire op_bsr  = (ir_cur_ff == OP_SAMPLE) | (ir_cur_ff == OP_EXTEST);
  wire op_prog = (ir_cur_ff == OP_PROG);
  wire op_read = (ir_cur_ff == OP_READ);
  wire op_isp  = op_prog | op_read;
  wire op_byp  = ~(op_idu | op_bsr | op_isp);
  wire busy    = req_tgl_ff ^ ack_s;

  // Serial path
  wire [ID_W-1:0] id_cap = op_user ? USERCODE_VAL : IDCODE_VAL;
  wire [DATA_W-1:0] rd_word = sec_s ? {DATA_W{1'h0}} : rd_hold_ff;
  wire isp_out = isp_shift_ff.data[0];
  wire dr_out  = op_idu ? id_shift_ff[0] : op_bsr ? bsr_shift_ff[0] : op_isp ? isp_out : bypass_ff;

  wire [IR_W-1:0] nxt_ir_shift = in_cap_ir ? IR_CAPTURE :
                                 in_sh_ir  ? {TDI_I, ir_shift_ff[IR_W-1:1]} : ir_shift_ff;
  wire nxt_bypass = (in_cap_dr & op_byp) ? BYPASS_CAP :
                    (in_sh_dr & op_byp) ? TDI_I : bypass_ff;
  wire [ID_W-1:0] nxt_id = (in_cap_dr & op_idu) ? id_cap :
                           (in_sh_dr & op_idu) ? {TDI_I, id_shift_ff[ID_W-1:1]} : id_shift_ff;
  wire [BSR_LEN-1:0] nxt_bsr = (in_cap_dr & op_bsr) ? pins_s :
                               (in_sh_dr & op_bsr) ? {TDI_I, bsr_shift_ff[BSR_LEN-1:1]} : bsr_shift_ff;
  wire [ISP_W-1:0] nxt_isp = (in_cap_dr & op_read & ~busy) ? {isp_shift_ff.row, rd_word} :
                             (in_sh_dr & op_isp) ? {TDI_I, isp_shift_ff[ISP_W-1:1]} : isp_shift_ff;

  // Parallel updates on the falling edge
  wire [IR_W-1:0] nxt_ir_cur = in_tlr ? OP_IDCODE : in_upd_ir ? ir_shift_ff : ir_cur_ff;
  wire test_mode_t nxt_mode = mode_of(nxt_ir_cur);
  wire [BSR_LEN-1:0] nxt_bsr_upd = (in_upd_dr & op_bsr) ? bsr_shift_ff : bsr_upd_ff;
  wire req_go = in_upd_dr & op_isp & ~busy;
  wire isp_req_t nxt_req = req_go ? {op_prog, isp_shift_ff} : req_ff;
  wire nxt_req_tgl = req_tgl_ff ^ req_go;
  wire nxt_tdo = in_sh_ir ? ir_shift_ff[0] : in_sh_dr ? dr_out : 1'h0;

  // Shift stages, all rising edge
  always_ff @(posedge TCK_I or negedge tck_rst_b) begin
    if (!tck_rst_b) begin
      ir_shift_ff  <= IR_CAPTURE;
      bypass_ff    <= BYPASS_CAP;
      id_shift_ff  <= '0;
      bsr_shift_ff <= '0;
      isp_shift_ff <= '0;
    end else begin
      ir_shift_ff  <= nxt_ir_shift;
      bypass_ff    <= nxt_bypass;
      id_shift_ff  <= nxt_id;
      bsr_shift_ff <= nxt_bsr;
      isp_shift_ff <= nxt_isp;
    end
  end

  // Latched outputs, falling edge
  always_ff @(negedge TCK_I or negedge tck_rst_b) begin
    if (!tck_rst_b) begin
      ir_cur_ff  <= OP_IDCODE;
      mode_ff    <= '0;
      bsr_upd_ff <= '0;
      tdo_ff     <= 1'h0;
      tdo_oe_ff  <= 1'h0;
    end else begin
      ir_cur_ff  <= nxt_ir_cur;
      mode_ff    <= nxt_mode;
      bsr_upd_ff <= nxt_bsr_upd;
      tdo_ff     <= nxt_tdo;
      tdo_oe_ff  <= is_shift_state(state);
    end
  end

  // Request to the array, kept across a link-only reset
  always_ff @(negedge TCK_I or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      req_ff     <= '0;
      req_tgl_ff <= 1'h0;
    end else begin
      req_ff     <= nxt_req;
      req_tgl_ff <= nxt_req_tgl;
    end
  end

  // Array side
  wire new_req = req_s ^ req_seen_ff;
  wire isp_req_t nxt_prog_req = new_req ? req_ff : prog_req_ff;
  wire [DATA_W-1:0] nxt_rd_hold = ARRAY_ACK_I ? ARRAY_RDATA_I : rd_hold_ff;
  wire nxt_ack_tgl = ack_tgl_ff ^ ARRAY_ACK_I;
  // Mode bits may settle a cycle apart, so pass the word only once steady
  wire test_mode_t nxt_mode_out = (mode_s == mode_last_ff) ? mode_s : mode_out_ff;

  always_ff @(posedge CLK_I or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      req_seen_ff <= 1'h0;
      stb_ff      <= 1'h0;
      prog_req_ff <= '0;
      rd_hold_ff  <= '0;
      ack_tgl_ff  <= 1'h0;
      mode_last_ff <= '0;
      mode_out_ff  <= '0;
    end else begin
      req_seen_ff <= req_s;
      stb_ff      <= new_req;
      prog_req_ff <= nxt_prog_req;
      rd_hold_ff  <= nxt_rd_hold;
      ack_tgl_ff  <= nxt_ack_tgl;
      mode_last_ff <= mode_s;
      mode_out_ff  <= nxt_mode_out;
    end
  end

  // Outputs
  assign TDO_O      = tdo_ff;
  assign TDO_OE_O   = tdo_oe_ff;
  assign PIN_OUT_O  = bsr_upd_ff;
  assign PIN_TEST_O = mode_ff.extest;
  assign PIN_HIZ_O  = mode_ff.highz;
  assign PROG_STB_O = stb_ff;
  assign PROG_REQ_O = prog_req_ff;
  assign MODE_O     = mode_out_ff;

  sequence id_cap_s;
    in_cap_dr && op_id;
  endsequence

  sequence first_shift_s;
    in_sh_dr;
  endsequence

  ir_tlr_a: assert property (@(posedge TCK_I) disable iff (!tck_rst_b)
    in_tlr |=> (ir_cur_ff == OP_IDCODE) && (mode_ff == '0)) else $error("Reset state kept test logic");
  ir_idle_a: assert property (@(posedge TCK_I) disable iff (!tck_rst_b)
    in_rti |=> $stable(ir_cur_ff)) else $error("Instruction changed in idle");
  dr_idle_a: assert property (@(posedge TCK_I) disable iff (!tck_rst_b)
    in_rti |=> $stable(id_shift_ff) && $stable(bsr_shift_ff) && $stable(isp_shift_ff) && $stable(bypass_ff))
    else $error("Data register moved in idle");
  ir_shield_a: assert property (@(posedge TCK_I) disable iff (!tck_rst_b)
    !(in_upd_ir || in_tlr) |-> $stable(ir_cur_ff)) else $error("Instruction changed outside update");
  ir_update_a: assert property (@(posedge TCK_I) disable iff (!tck_rst_b)
    in_upd_ir |=> (ir_cur_ff == $past(ir_shift_ff))) else $error("Instruction not latched in update");
  id_out_a: assert property (@(posedge TCK_I) disable iff (!tck_rst_b)
    id_cap_s ##1 first_shift_s |-> (id_shift_ff == IDCODE_VAL) && (dr_out == IDCODE_VAL[0]))
    else $error("Identity word not presented");
  id_shift_a: assert property (@(posedge TCK_I) disable iff (!tck_rst_b)
    in_sh_dr && op_idu |=> (id_shift_ff == {$past(TDI_I), $past(id_shift_ff[ID_W-1:1])}))
    else $error("Identity register did not shift");
  bypass_one_a: assert property (@(posedge TCK_I) disable iff (!tck_rst_b)
    in_sh_dr && op_byp |=> (bypass_ff == $past(TDI_I)) && (dr_out == $past(TDI_I)))
    else $error("Bypass stage wrong");
  tdo_idle_a: assert property (@(posedge TCK_I) disable iff (!tck_rst_b)
    (tdo_oe_ff == is_shift_state(state)) && (!tdo_oe_ff -> !tdo_ff)) else $error("Output active outside shift");
  sec_read_a: assert property (@(posedge TCK_I) disable iff (!tck_rst_b)
    in_cap_dr && op_read && !busy && sec_s |=> (isp_shift_ff.data == '0)) else $error("Secured data read back");
  prog_stb_a: assert property (@(posedge CLK_I) disable iff (!rst_sync_ff)
    $changed(req_s) |=> PROG_STB_O && (PROG_REQ_O == req_ff) ##1 !PROG_STB_O) else $error("Array request lost");

endmodule : jtag_tap_isp_port
`default_nettype wire

// ==== verification/jtag_host.sv ====
// Purpose: Host model driving the test port
// Assumes: TCK stands still between frames
// Notes:   TMS and TDI change while TCK is low; TDI idles high
`timescale 1ns/10ps
`default_nettype none
module jtag_host (
  // Test port
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // One 48 ns TCK cycle; TDO taken just before the rise
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #24;
    tdo = tdo_i;
    tck_o = 1'b1;
    #24;
    tck_o = 1'b0;
  endtask : tick
  // Five TMS-high edges reach reset from anywhere, then idle
  task automatic to_idle();
    logic t;
    repeat (5) tick(1'b1, 1'b1, t);
    tick(1'b0, 1'b1, t);
  endtask : to_idle
  // Full scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic t;
    dout = '0;
    tick(1'b1, 1'b1, t);
    if (ir) tick(1'b1, 1'b1, t);
    tick(1'b0, 1'b1, t);
    tick(1'b0, 1'b1, t);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], t);
      dout[i] = t;
    end
    tick(1'b1, 1'b1, t);
    tick(1'b0, 1'b1, t);
  endtask : scan
endmodule : jtag_host
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: Self-checking bench of the test access port
// Assumes: Default opcodes and identity values
// Notes:   Array model acks three cycles after each strobe
`timescale 1ns/10ps
`default_nettype none
module tb
  import jtag_tap_pkg::*;
;
  logic        clk, rst_b, trst_b, sec, ack, tdo, tdo_oe, pin_test, pin_hiz, stb, t;
  logic [15:0] pin_in, rdata, pin_out, rd_val;
  logic [31:0] got;
  logic [2:0]  pend;
  wire         tck, tms, tdi, tdo_w;
  test_mode_t  mode;
  isp_req_t    req, req_q;
  int          num_errors, check_count, n_stb, n0, cyc;
  // TDO line has a pull-up when released
  assign tdo_w = (tdo_oe === 1'b1) ? tdo : 1'b1;
  jtag_tap_isp_port jtag_tap_isp_port_inst (
    .CLK_I(clk), .RST_B_I(rst_b), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
    .TRST_B_I(trst_b), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .PIN_IN_I(pin_in),
    .PIN_OUT_O(pin_out), .PIN_TEST_O(pin_test), .PIN_HIZ_O(pin_hiz), .MODE_O(mode),
    .SEC_I(sec), .ARRAY_ACK_I(ack), .ARRAY_RDATA_I(rdata), .PROG_STB_O(stb),
    .PROG_REQ_O(req));
  jtag_host jtag_host_inst (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo_w));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Array model; data lines toggle outside the ack cycle
  always @(negedge clk) begin
    pend  <= {pend[1:0], stb === 1'b1};
    ack   <= pend[2];
    rdata <= pend[2] ? rd_val : ~rdata;
    if (stb === 1'b1) begin
      req_q <= req;
      n_stb <= n_stb + 1;
    end
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      finish_test();
    end
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h, expected %h", $time, g, e);
    end
  endtask : chk
  task automatic ir(input logic [3:0] op);
    jtag_host_inst.scan(1'b1, 4, {28'h000_0000, op}, got);
  endtask : ir
  task automatic wait_req();
    for (int i = 0; i < 40 && n_stb == n0; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    repeat (8) jtag_host_inst.tick(1'b0, 1'b1, t);
  endtask : wait_req
  task automatic t_ident();
    jtag_host_inst.to_idle();
    jtag_host_inst.scan(1'b0, 32, '0, got);
    chk(got, IDCODE_DEF);
    chk(tdo_oe, 1'b0);
    $display("test ident finished");
  endtask : t_ident
  task automatic t_bypass();
    logic [11:0] ops;
    ops = {OP_HIGHZ_DEF, 4'h7, OP_BYPASS_DEF};
    for (int k = 0; k < 3; k++) begin
      jtag_host_inst.scan(1'b1, 4, {28'h000_0000, ops[4*k +: 4]}, got);
      chk(got[3:0], IR_CAPTURE);
      jtag_host_inst.scan(1'b0, 2, 32'h0000_0001, got);
      chk(got[1:0], 2'h2);
      chk(pin_hiz, ops[4*k +: 4] == OP_HIGHZ_DEF);
    end
    ir(OP_USERCODE_DEF);
    jtag_host_inst.scan(1'b0, 32, 32'hFFFF_FFFF, got);
    chk(got, USERCODE_DEF);
    $display("test bypass finished");
  endtask : t_bypass
  task automatic t_bscan();
    @(negedge clk) pin_in = 16'hA5C3;
    ir(OP_SAMPLE_DEF);
    jtag_host_inst.scan(1'b0, 16, 32'h0000_1234, got);
    chk(got[15:0], 16'hA5C3);
    chk(pin_out, 16'h1234);
    repeat (20) jtag_host_inst.tick(1'b0, 1'b1, t);
    chk(pin_out, 16'h1234);
    ir(OP_EXTEST_DEF);
    repeat (10) @(posedge clk);
    chk({pin_test, mode.extest}, 2'h3);
    repeat (3) jtag_host_inst.tick(t, 1'b1, t);
    jtag_host_inst.to_idle();
    chk(pin_test, 1'b0);
    jtag_host_inst.scan(1'b0, 32, '0, got);
    chk(got, IDCODE_DEF);
    $display("test boundary finished");
  endtask : t_bscan
  task automatic t_isp();
    ir(OP_PROG_DEF);
    n0 = n_stb;
    jtag_host_inst.scan(1'b0, 24, 32'h005A_1234, got);
    wait_req();
    chk(req_q, {1'b1, 8'h5A, 16'h1234});
    rd_val = 16'hBEEF;
    ir(OP_READ_DEF);
    n0 = n_stb;
    jtag_host_inst.scan(1'b0, 24, 32'h0033_0000, got);
    wait_req();
    chk(req_q, {1'b0, 8'h33, 16'h0000});
    n0 = n_stb;
    jtag_host_inst.scan(1'b0, 24, 32'h0033_0000, got);
    chk(got[23:0], 24'h33_BEEF);
    @(negedge clk) sec = 1'b1;
    wait_req();
    jtag_host_inst.scan(1'b0, 24, '0, got);
    chk(got[15:0], 16'h0000);
    $display("test programming finished");
  endtask : t_isp
  task automatic t_trst();
    ir(OP_USERCODE_DEF);
    @(negedge clk) trst_b = 1'b0;
    #100;
    trst_b = 1'b1;
    repeat (3) jtag_host_inst.tick(1'b0, 1'b1, t);
    jtag_host_inst.scan(1'b0, 32, '0, got);
    chk(got, IDCODE_DEF);
    $display("test link reset finished");
  endtask : t_trst
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : finish_test
  initial begin
    {rst_b, sec, ack, pend, n_stb, cyc} = '0;
    {num_errors, check_count} = '0;
    trst_b = 1'b1;
    pin_in = 16'h0000;
    rdata  = 16'h0F0F;
    rd_val = 16'h0000;
    repeat (16) @(posedge clk);
    @(negedge clk) rst_b = 1'b1;
    #7;
    t_ident();
    t_bypass();
    t_bscan();
    t_isp();
    t_trst();
    finish_test();
  end
endmodule : tb
`default_nettype wire
